//--- verilog/capr_pkg.sv
// Constants shared by the capabilities payload block and its testbench
package capr_pkg;

  // ****************************************************************
  // Register byte offsets on the APB bus
  // ****************************************************************
  localparam logic [7:0] CAPR_OFF_CTRL  = 8'h00; // Build and arb status
  localparam logic [7:0] CAPR_OFF_STAT  = 8'h04; // Busy and done
  localparam logic [7:0] CAPR_OFF_FLAGS = 8'h08; // Live flag word
  localparam logic [7:0] CAPR_OFF_BCAST = 8'h0c; // Broadcast filter mask
  localparam logic [7:0] CAPR_OFF_MCAST = 8'h10; // Multicast filter mask
  localparam logic [7:0] CAPR_OFF_BUF   = 8'h14; // Buffering in bytes
  localparam logic [7:0] CAPR_OFF_CNT   = 8'h18; // Filter counts
  localparam logic [7:0] CAPR_OFF_PAY   = 8'h20; // First payload word

  // ****************************************************************
  // Payload buffer shape
  // ****************************************************************
  localparam int          CAPR_PAY_WORDS = 5;     // Words per payload
  localparam int          CAPR_PAY_AW    = 3;     // Buffer address bits
  localparam logic [2:0]  CAPR_PAY_LAST  = 3'h4;  // Index of last word

  // ****************************************************************
  // Capability flag word positions
  // ****************************************************************
  localparam int CAPR_FLG_HW_ARB  = 0; // Hardware arbitration capable
  localparam int CAPR_FLG_DRV     = 1; // Host driver status reporting
  localparam int CAPR_FLG_NC2MC   = 2; // Flow control toward manager
  localparam int CAPR_FLG_MC2NC   = 3; // Flow control from manager
  localparam int CAPR_FLG_ALLMC   = 4; // All-multicast support
  localparam int CAPR_FLG_ARB_LO  = 5; // Arbitration status, 2 bits
  localparam int CAPR_FLG_THERM   = 7; // Thermal self-shutdown
  localparam int CAPR_FLG_DLY     = 8; // Delayed response
  localparam int CAPR_FLG_RSV_LO  = 9; // First reserved position

  // ****************************************************************
  // Control, status and count field positions
  // ****************************************************************
  localparam int CAPR_CTRL_BUILD  = 0;  // Write 1 to build payload
  localparam int CAPR_CTRL_ARB_LO = 1;  // Arbitration status field
  localparam int CAPR_STAT_BUSY   = 0;  // Build in progress
  localparam int CAPR_STAT_DONE   = 1;  // Sticky, write 1 to clear
  localparam int CAPR_CNT_UC_LO   = 0;  // Unicast filter count
  localparam int CAPR_CNT_MC_LO   = 8;  // Multicast filter count
  localparam int CAPR_CNT_MX_LO   = 16; // Mixed filter count
  localparam int CAPR_CNT_VL_LO   = 24; // VLAN filter count

  // ****************************************************************
  // Limits on reported counts
  // ****************************************************************
  localparam int CAPR_VLAN_MAX    = 15; // Most VLAN filters
  localparam int CAPR_ADDR_MAX    = 8;  // Most address filters

  // ****************************************************************
  // Enumerations and reset values
  // ****************************************************************
  typedef enum logic [1:0] {
    CAPR_ARB_UNKNOWN  = 2'b00,
    CAPR_ARB_NOT_IMPL = 2'b01,
    CAPR_ARB_IMPL     = 2'b10,
    CAPR_ARB_RSVD     = 2'b11
  } capr_arb_t;

  typedef enum logic [0:0] {
    CAPR_ST_IDLE = 1'b0,
    CAPR_ST_FILL = 1'b1
  } capr_state_t;

  localparam capr_arb_t CAPR_ARB_RST = CAPR_ARB_UNKNOWN; // Until told

endpackage

//--- verilog/capr_pay_if.sv
// Write and read port bundle between the builder and its payload buffer
`timescale 1ns/1ps
interface capr_pay_if #(
  parameter int W  = 32,
  parameter int AW = 3
);
  logic          we;    // Write strobe
  logic [AW-1:0] waddr; // Write word index
  logic [W-1:0]  wdata; // Write word
  logic [AW-1:0] raddr; // Read word index
  logic [W-1:0]  rdata; // Registered read word

  modport ctl (output we, output waddr, output wdata, output raddr,
               input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
               output rdata);
endinterface

//--- verilog/capr_pay_mem.sv
// Small payload buffer with registered read data
`timescale 1ns/1ps
module capr_pay_mem #(
  parameter int W     = 32,
  parameter int AW    = 3,
  parameter int DEPTH = 5
) (
  // Clock
  input wire logic pclk,
  // Buffer ports
  capr_pay_if.mem  port
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [W-1:0] mem_r [DEPTH]; // Payload words, not reset

  // Write port
  always_ff @(posedge pclk)
  begin
    if (port.we && (32'(port.waddr) < DEPTH))
    begin
      mem_r[port.waddr] <= port.wdata;
    end
  end

  // Read port; out of range indexes read as zero
  always_ff @(posedge pclk)
  begin
    if (32'(port.raddr) < DEPTH)
    begin
      port.rdata <= mem_r[port.raddr];
    end
    else
    begin
      port.rdata <= '0;
    end
  end

endmodule // capr_pay_mem

//--- verilog/capr_top.sv
// Capabilities response payload builder with APB register access
`timescale 1ns/1ps
module capr_top
  import capr_pkg::*;
#(
  parameter bit          HW_ARB_CAP   = 1'b0,   // Package arbitration
  parameter bit          DRV_CAP      = 1'b0,   // Driver status report
  parameter bit          NC2MC_FC     = 1'b0,   // Flow control out
  parameter bit          MC2NC_FC     = 1'b0,   // Flow control in
  parameter bit          ALLMC_CAP    = 1'b0,   // All-multicast
  parameter bit          THERM_CAP    = 1'b0,   // Thermal shutdown
  parameter bit          DLY_CAP      = 1'b0,   // Delayed response
  parameter logic [31:0] BCAST_MASK   = 32'h0000_0000, // Built filters
  parameter logic [31:0] MCAST_MASK   = 32'h0000_0000, // Built filters
  parameter logic [31:0] BUF_BYTES    = 32'h0000_0000, // 0 unspecified
  parameter int          VLAN_FILTERS = 0,      // VLAN filters built
  parameter int          MIXED_FILTERS = 0,     // Mixed filters built
  parameter int          MCAST_FILTERS = 0,     // Multicast built
  parameter int          UCAST_FILTERS = 1      // Unicast built
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ****************************************************************
  // Reported counts, legalised at elaboration
  // ****************************************************************
  // Counts are clamped rather than trusted, so a wrong parameter
  // can never produce an illegal answer on the wire.
  localparam int VL_N = (VLAN_FILTERS > CAPR_VLAN_MAX) ?
                        CAPR_VLAN_MAX : VLAN_FILTERS;
  localparam int UC_A = (UCAST_FILTERS + MIXED_FILTERS == 0) ?
                        1 : UCAST_FILTERS;
  localparam int UC_N = (UC_A > CAPR_ADDR_MAX) ? CAPR_ADDR_MAX : UC_A;
  localparam int MX_N = (MIXED_FILTERS > CAPR_ADDR_MAX - UC_N) ?
                        CAPR_ADDR_MAX - UC_N : MIXED_FILTERS;
  localparam int MC_N = (MCAST_FILTERS > CAPR_ADDR_MAX - UC_N - MX_N) ?
                        CAPR_ADDR_MAX - UC_N - MX_N : MCAST_FILTERS;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  capr_arb_t   arb_r;       // Arbitration status held for software
  capr_state_t state_r;     // Build sequencer state
  logic [2:0]  idx_r;       // Payload word being written
  logic        done_r;      // Sticky build completion
  logic        pend_r;      // Payload read waiting for buffer data
  logic [31:0] prdata_r;    // Read data flop
  logic        pready_r;    // Ready flop
  logic        pslverr_r;   // Error flop
  logic [31:0] flags_w;     // Live capability flag word
  logic [31:0] cnt_w;       // Live filter count word
  logic        setup_w;     // APB setup phase
  logic        done_acc_w;  // APB access completing this edge
  logic        wr_w;        // Completing write

  capr_pay_if #(.W(32), .AW(CAPR_PAY_AW)) pay ();

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Mapped register offsets
  function automatic logic reg_hit(input logic [7:0] a);
    return (a == CAPR_OFF_CTRL) || (a == CAPR_OFF_STAT) ||
           (a == CAPR_OFF_FLAGS) || (a == CAPR_OFF_BCAST) ||
           (a == CAPR_OFF_MCAST) || (a == CAPR_OFF_BUF) ||
           (a == CAPR_OFF_CNT);
  endfunction

  // Aligned word inside the payload window
  function automatic logic pay_hit(input logic [7:0] a);
    return (a >= CAPR_OFF_PAY) && (a[1:0] == 2'b00) &&
           (a < CAPR_OFF_PAY + 8'(4 * CAPR_PAY_WORDS));
  endfunction

  assign setup_w    = psel && !penable;
  assign done_acc_w = psel && penable && pready_r;
  assign wr_w       = done_acc_w && pwrite;

  // ****************************************************************
  // Capability words
  // ****************************************************************
  // Flag word from fixed build choices plus software arb status
  always_comb
  begin
    flags_w                  = '0;
    flags_w[CAPR_FLG_HW_ARB] = HW_ARB_CAP;
    flags_w[CAPR_FLG_DRV]    = DRV_CAP;
    flags_w[CAPR_FLG_NC2MC]  = NC2MC_FC;
    flags_w[CAPR_FLG_MC2NC]  = MC2NC_FC;
    flags_w[CAPR_FLG_ALLMC]  = ALLMC_CAP;
    flags_w[CAPR_FLG_ARB_LO +: 2] = arb_r;
    flags_w[CAPR_FLG_THERM]  = THERM_CAP;
    flags_w[CAPR_FLG_DLY]    = DLY_CAP;
  end

  // Packed counts, one byte each
  always_comb
  begin
    cnt_w                      = '0;
    cnt_w[CAPR_CNT_VL_LO +: 8] = 8'(VL_N);
    cnt_w[CAPR_CNT_MX_LO +: 8] = 8'(MX_N);
    cnt_w[CAPR_CNT_MC_LO +: 8] = 8'(MC_N);
    cnt_w[CAPR_CNT_UC_LO +: 8] = 8'(UC_N);
  end

  // Payload word by index, in response order
  function automatic logic [31:0] pay_word(input logic [2:0] i);
    unique case (i)
      3'h0:    return flags_w;
      3'h1:    return BCAST_MASK;
      3'h2:    return MCAST_MASK;
      3'h3:    return BUF_BYTES;
      default: return cnt_w;
    endcase
  endfunction

  // ****************************************************************
  // Arbitration status register
  // ****************************************************************
  // The reserved code is refused, so 11b can never be reported
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arb_r <= CAPR_ARB_RST;
    end
    else if (wr_w && paddr == CAPR_OFF_CTRL &&
             pwdata[CAPR_CTRL_ARB_LO +: 2] != CAPR_ARB_RSVD)
    begin
      arb_r <= capr_arb_t'(pwdata[CAPR_CTRL_ARB_LO +: 2]);
    end
  end

  // ****************************************************************
  // Build sequencer
  // ****************************************************************
  // Copies one snapshot of every word into the buffer, so a query
  // in progress never sees a half-updated arbitration field.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= CAPR_ST_IDLE;
      idx_r   <= 3'h0;
    end
    else
    begin
      unique case (state_r)
        CAPR_ST_IDLE:
        begin
          // Start request; ignored while busy
          if (wr_w && paddr == CAPR_OFF_CTRL && pwdata[CAPR_CTRL_BUILD])
          begin
            state_r <= CAPR_ST_FILL;
            idx_r   <= 3'h0;
          end
        end
        CAPR_ST_FILL:
        begin
          // One word per cycle
          if (idx_r == CAPR_PAY_LAST)
          begin
            state_r <= CAPR_ST_IDLE;
          end
          idx_r <= idx_r + 3'h1;
        end
      endcase
    end
  end

  // Sticky done; a new completion beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_r <= 1'b0;
    end
    else if (state_r == CAPR_ST_FILL && idx_r == CAPR_PAY_LAST)
    begin
      done_r <= 1'b1;
    end
    else if (wr_w && paddr == CAPR_OFF_STAT && pwdata[CAPR_STAT_DONE])
    begin
      done_r <= 1'b0;
    end
  end

  // Buffer ports
  assign pay.we    = (state_r == CAPR_ST_FILL);
  assign pay.waddr = idx_r;
  assign pay.wdata = pay_word(idx_r);
  assign pay.raddr = 3'(paddr[7:2] - CAPR_OFF_PAY[7:2]);

  capr_pay_mem #(
    .W     (32),
    .AW    (CAPR_PAY_AW),
    .DEPTH (CAPR_PAY_WORDS)
  ) u_mem (
    .pclk (pclk),
    .port (pay.mem)
  );

  // ****************************************************************
  // APB responder
  // ****************************************************************
  // Registers answer with no wait state; payload reads take one
  // because the buffer read data is registered.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
      pend_r    <= 1'b0;
    end
    else if (setup_w && !pwrite && pay_hit(paddr))
    begin
      // Wait one cycle for buffer data
      pend_r   <= 1'b1;
      pready_r <= 1'b0;
    end
    else if (setup_w)
    begin
      // Register access or unmapped address
      pready_r  <= 1'b1;
      pslverr_r <= !reg_hit(paddr);
      prdata_r  <= '0;
      if (!pwrite)
      begin
        unique case (paddr)
          CAPR_OFF_CTRL:  prdata_r[CAPR_CTRL_ARB_LO +: 2] <= arb_r;
          CAPR_OFF_STAT:  prdata_r[1:0] <= {done_r,
                                            state_r == CAPR_ST_FILL};
          CAPR_OFF_FLAGS: prdata_r <= flags_w;
          CAPR_OFF_BCAST: prdata_r <= BCAST_MASK;
          CAPR_OFF_MCAST: prdata_r <= MCAST_MASK;
          CAPR_OFF_BUF:   prdata_r <= BUF_BYTES;
          CAPR_OFF_CNT:   prdata_r <= cnt_w;
          default:        prdata_r <= '0;
        endcase
      end
    end
    else if (pend_r)
    begin
      // Buffer data now valid
      pend_r    <= 1'b0;
      pready_r  <= 1'b1;
      pslverr_r <= 1'b0;
      prdata_r  <= pay.rdata;
    end
    else
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flag_low_bits: assert property (
    done_acc_w && !pwrite && paddr == CAPR_OFF_FLAGS |->
      prdata[4:0] == {ALLMC_CAP, MC2NC_FC, NC2MC_FC, DRV_CAP,
                      HW_ARB_CAP})
    else $error("flag bits 4:0 differ from build choices");

  a_arb_never_rsvd: assert property (
    done_acc_w && !pwrite && paddr == CAPR_OFF_FLAGS |->
      prdata[CAPR_FLG_ARB_LO +: 2] != CAPR_ARB_RSVD)
    else $error("reserved arbitration code reported");

  a_arb_write_taken: assert property (
    wr_w && paddr == CAPR_OFF_CTRL |=>
      arb_r == (($past(pwdata[2:1]) == 2'b11) ? $past(arb_r)
                                               : $past(pwdata[2:1])))
    else $error("arbitration status write mishandled");

  a_flag_high_bits: assert property (
    done_acc_w && !pwrite && paddr == CAPR_OFF_FLAGS |->
      prdata[31:7] == {23'h0, DLY_CAP, THERM_CAP})
    else $error("flag bits 31:7 wrong");

  a_mask_words: assert property (
    setup_w && !pwrite && paddr == CAPR_OFF_BCAST |=>
      pready && prdata == BCAST_MASK)
    else $error("broadcast mask read wrong");

  a_count_limits: assert property (
    done_acc_w && !pwrite && paddr == CAPR_OFF_CNT |->
      prdata[31:24] <= 8'h0f && (prdata[7:0] + prdata[23:16]) != 8'h0 &&
      (prdata[7:0] + prdata[15:8] + prdata[23:16]) <= 8'h08)
    else $error("filter counts out of limits");

  a_build_length: assert property (
    $rose(state_r == CAPR_ST_FILL) |->
      (state_r == CAPR_ST_FILL)[*5] ##1 (state_r == CAPR_ST_IDLE && done_r))
    else $error("build did not take five cycles");

  a_payload_match: assert property (
    setup_w && !pwrite && paddr == CAPR_OFF_PAY + 8'h10 && done_r &&
    state_r == CAPR_ST_IDLE |-> ##2 pready && prdata == cnt_w)
    else $error("stored count word differs from live value");

endmodule // capr_top

//--- tb/capr_mgr_model.sv
// Management-side APB master model that issues capability queries
`timescale 1ns/1ps
module capr_mgr_model (
  // Clock
  input  wire logic        pclk,
  // APB master outputs
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // APB slave answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Bus idle from time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // One transfer: setup, then access held until pready at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait as long as the slave asks; the bench timeout catches a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines show no stale value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // capr_mgr_model

//--- tb/capr_top_tb_top.sv
// Self-checking bench for the capabilities payload builder
`timescale 1ns/1ps
module capr_top_tb_top;
  import capr_pkg::*;
  // ****************************************************************
  // Clock, reset and bus
  // ****************************************************************
  logic        pclk    = 1'b0;  // 50 MHz
  logic        presetn = 1'b0;  // Active low
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          n_mismatch = 0;  // Failed compares
  int          compares   = 0;  // All compares
  int          cyc        = 0;  // Timeout counter
  logic [31:0] cnt_seen;        // Count word read before a build
  // Fixed part of the flag word for the parameters below
  localparam logic [31:0] FLG = 32'h0000_0001;
  // Legal count word: vlan 15, mixed 4, mcast trimmed to 3, ucast 1
  localparam logic [31:0] CNT = 32'h0f04_0301;

  always #10 pclk = ~pclk;

`define CHK(g, x) begin compares++; if ((g) !== (x)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (x)); end end

  // Vlan count above the limit, an oversized address total, arbitration
  // capable and a broadcast mask of 0xf; the other build choices keep their defaults
  capr_top #(.HW_ARB_CAP(1'b1), .BCAST_MASK(32'h0000_000f),
    .VLAN_FILTERS(20), .MIXED_FILTERS(4), .MCAST_FILTERS(5)) capr_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  capr_mgr_model capr_mgr_model_i (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ****************************************************************
  // Bus helpers and closing report
  // ****************************************************************
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    capr_mgr_model_i.xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    capr_mgr_model_i.xfer(1'b1, a, d, q, e);
  endtask

  task automatic stop_test;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, well above the hundred or so cycles needed
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_fields;
    logic [31:0] q;
    rd(CAPR_OFF_FLAGS, q);
    `CHK(q, FLG)
    rd(CAPR_OFF_BCAST, q);
    `CHK(q, 32'h0000_000f)
    rd(CAPR_OFF_MCAST, q);
    `CHK(q, 32'h0000_0000)
    rd(CAPR_OFF_BUF, q);
    `CHK(q, 32'h0000_0000)
    $display("test fields done");
  endtask

  // Every arbitration code, the reserved one must not stick
  task automatic t_arb;
    logic [31:0] q;
    logic [1:0]  code [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
    logic [1:0]  held;
    held = 2'b00;
    for (int i = 0; i < 4; i++)
    begin
      wr(CAPR_OFF_CTRL, {29'h0, code[i], 1'b0});
      if (code[i] != 2'b11)
        held = code[i];
      rd(CAPR_OFF_FLAGS, q);
      `CHK(q, FLG | {25'h0, held, 5'h0})
    end
    $display("test arb done");
  endtask

  task automatic t_counts;
    rd(CAPR_OFF_CNT, cnt_seen);
    `CHK(cnt_seen[31:24], 8'h0f)
    `CHK(cnt_seen[7:0], 8'h01)
    `CHK(cnt_seen[23:16], 8'h04)
    `CHK(cnt_seen[15:8], 8'h03)
    `CHK(cnt_seen[7:0] + cnt_seen[15:8] + cnt_seen[23:16], 8'h08)
    `CHK(cnt_seen, CNT)
    $display("test counts done");
  endtask

  // Build with arb implemented, then payload and a repeat query
  task automatic t_build;
    logic [31:0] q;
    logic [31:0] exp [5];
    exp = '{FLG | 32'h40, 32'h0000_000f, 32'h0000_0000, 32'h0000_0000,
            CNT};
    wr(CAPR_OFF_CTRL, 32'h0000_0005);
    q = 32'h0;
    for (int i = 0; i < 20 && q[CAPR_STAT_DONE] !== 1'b1; i++)
      rd(CAPR_OFF_STAT, q);
    `CHK(q, 32'h0000_0002)
    for (int i = 0; i < CAPR_PAY_WORDS; i++)
    begin
      rd(CAPR_OFF_PAY + 8'(4 * i), q);
      `CHK(q, exp[i])
    end
    rd(CAPR_OFF_CNT, q);
    `CHK(q, cnt_seen)
    wr(CAPR_OFF_STAT, 32'h0000_0002);
    rd(CAPR_OFF_STAT, q);
    `CHK(q, 32'h0)
    $display("test build done");
  endtask

  // Unmapped read, payload write, write to the read-only flag word
  task automatic t_errors;
    logic [31:0] q;
    logic        e;
    capr_mgr_model_i.xfer(1'b0, 8'h1c, 32'h0, q, e);
    `CHK({e, q}, {1'b1, 32'h0})
    capr_mgr_model_i.xfer(1'b1, CAPR_OFF_PAY, 32'hffff_ffff, q, e);
    `CHK(e, 1'b1)
    capr_mgr_model_i.xfer(1'b1, CAPR_OFF_FLAGS, 32'hffff_ffff, q, e);
    `CHK(e, 1'b0)
    rd(CAPR_OFF_FLAGS, q);
    `CHK(q, FLG | 32'h40)
    $display("test errors done");
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_fields();
    t_arb();
    t_counts();
    t_build();
    t_errors();
    stop_test();
  end
endmodule // capr_top_tb_top
